// ---- hdl/scaler_defines.vh ----
// Purpose: shared constants of the video scaler
// Assumes: one colour plane of 8-bit samples per beat
// Notes:   definitions only
`ifndef SCALER_DEFINES_VH
`define SCALER_DEFINES_VH
`define DATA_W     8
`define CNT_W      16
`define FRAC_H     4
`define FRAC_V     3
`define ONE_H      5'h10
`define ONE_V      4'h8
`define MUL_W      9
`define ACC_LSB    7
`define RAM_AW     10
`define RAM_DEPTH  640
`define MAX_W      16'h0280
`define MAX_H      16'h01e0
`define PKT_VIDEO  4'h0
`define PKT_CTRL   4'hf
`define CTL_BEATS  4'h8
`define DIV_STEPS  6'h20
`define REG_CTRL   3'h0
`define REG_STATUS 3'h1
`define REG_OUTW   3'h2
`define REG_OUTH   3'h3
`define REG_INW    3'h4
`define REG_INH    3'h5
`define CTRL_GO    0
`define CTRL_BIL   1
`endif

// ---- hdl/scaler_divider.v ----
// Purpose: sequential unsigned divider, one quotient bit per cycle
// Assumes: start is a one-cycle pulse while idle
// Notes:   done pulses once when quotient and remainder are valid
`include "scaler_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module scaler_divider
(
  // clock and reset
  input  wire        clk,
  input  wire        rstN,
  // request
  input  wire        start,
  input  wire [31:0] num,
  input  wire [15:0] den,
  // answer
  output reg         done,
  output reg  [31:0] quot,
  output reg  [15:0] rem
);
  reg  [15:0] denR;
  reg  [5:0]  steps;
  wire [16:0] shifted = {rem, quot[31]};
  wire        fits    = shifted >= {1'b0, denR};
  wire [16:0] diff    = shifted - {1'b0, denR};

  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      done  <= 1'b0;
      quot  <= 32'h0;
      rem   <= 16'h0;
      denR  <= 16'h0;
      steps <= 6'h0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        quot  <= num;
        rem   <= 16'h0;
        denR  <= den;
        steps <= `DIV_STEPS;
      end
      else if (steps != 6'h0)
      begin
        quot  <= {quot[30:0], fits};
        rem   <= fits ? diff[15:0] : shifted[15:0];
        steps <= steps - 6'h01;
        done  <= (steps == 6'h01);
      end
    end
  end
endmodule
`default_nettype wire

// ---- hdl/scaler_line_ram.v ----
// Purpose: one clipped input line of samples
// Assumes: single write port, single read port
// Notes:   read data appear one clock after the address
`include "scaler_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module scaler_line_ram
(
  // clock and reset
  input  wire                 clk,
  input  wire                 rstN,
  // write side
  input  wire                 wrEn,
  input  wire [`RAM_AW-1:0]   wrAddr,
  input  wire [`DATA_W-1:0]   wrData,
  // read side
  input  wire [`RAM_AW-1:0]   rdAddr,
  output reg  [`DATA_W-1:0]   rdData
);
  reg [`DATA_W-1:0] mem [0:`RAM_DEPTH-1];

  always @(posedge clk)
  begin
    if (wrEn)
      mem[wrAddr] <= wrData;
  end

  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      rdData <= {`DATA_W{1'b0}};
    else
      rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire

// ---- hdl/video_scaler_nn_bilinear.v ----
// Purpose: nearest-neighbour / bilinear video resizer
// Assumes: one plane per beat, packet type in the low nibble of the
//          first beat, geometry nibbles msb first in control packets
// Notes:   one output pixel at a time, divider paced
`include "scaler_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module video_scaler_nn_bilinear
(
  // clock and reset
  input  wire                sys_clk,
  input  wire                rst_n,
  // register bus slave
  input  wire [2:0]          avAddress,
  input  wire                avRead,
  input  wire                avWrite,
  input  wire [31:0]         avWriteData,
  output reg  [31:0]         avReadData,
  output wire                avWaitRequest,
  // video in
  input  wire [`DATA_W-1:0]  dinData,
  input  wire                dinValid,
  input  wire                dinStartOfPacket,
  input  wire                dinEndOfPacket,
  output wire                dinReady,
  // video out
  output reg  [`DATA_W-1:0]  doutData,
  output reg                 doutValid,
  output reg                 doutStartOfPacket,
  output reg                 doutEndOfPacket,
  input  wire                doutReady
);
  localparam S_IDLE    = 5'h00;
  localparam S_CTRL    = 5'h01;
  localparam S_DROP    = 5'h02;
  localparam S_OUTHDR  = 5'h03;
  localparam S_ROWCALC = 5'h04;
  localparam S_ROWDIV  = 5'h05;
  localparam S_ROWERR  = 5'h06;
  localparam S_LOAD    = 5'h07;
  localparam S_COLCALC = 5'h08;
  localparam S_COLDIV  = 5'h09;
  localparam S_COLERR  = 5'h0a;
  localparam S_READ    = 5'h0b;
  localparam S_READ2   = 5'h0c;
  localparam S_READ3   = 5'h0d;
  localparam S_CALC    = 5'h0e;
  localparam S_EMIT    = 5'h0f;
  localparam S_STREAM  = 5'h10;

  // ==========================================================
  // reset release
  // ==========================================================
  reg rstMetaN;
  reg rstN;

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMetaN <= 1'b0;
      rstN     <= 1'b0;
    end
    else
    begin
      rstMetaN <= 1'b1;
      rstN     <= rstMetaN;
    end
  end

  // ==========================================================
  // declarations
  // ==========================================================
  reg  [4:0]         state;
  reg                go;
  reg                bilCfg;
  reg  [`CNT_W-1:0]  regOutW;
  reg  [`CNT_W-1:0]  regOutH;
  reg  [`CNT_W-1:0]  inW;
  reg  [`CNT_W-1:0]  inH;
  reg  [`CNT_W-1:0]  newW;
  reg  [`CNT_W-1:0]  newH;
  reg  [3:0]         ctlBeat;
  reg  [`CNT_W-1:0]  outW;
  reg  [`CNT_W-1:0]  outH;
  reg                bil;
  reg                direct;
  reg                inDone;
  reg  [`CNT_W-1:0]  i;
  reg  [`CNT_W-1:0]  j;
  reg  [`CNT_W-1:0]  x;
  reg  [`CNT_W-1:0]  y;
  reg  [`CNT_W-1:0]  srcCol;
  reg  [`CNT_W-1:0]  srcRow;
  reg  [`FRAC_H-1:0] errI;
  reg  [`FRAC_V-1:0] errJ;
  reg  [`DATA_W-1:0] pA;
  reg  [`DATA_W-1:0] pB;
  reg  [`DATA_W-1:0] pC;
  reg  [`DATA_W-1:0] pD;
  reg                avAck;
  reg                divStart;
  reg  [31:0]        divNum;
  reg  [15:0]        divDen;
  wire               divDone;
  wire [31:0]        divQuot;
  wire [15:0]        divRem;
  wire [`DATA_W-1:0] rdBus [0:1];

  wire take = dinValid & dinReady;
  wire outTake = doutValid & doutReady;

  // ==========================================================
  // index arithmetic
  // ==========================================================
  wire [31:0] w32 = {16'h0, inW};
  wire [31:0] h32 = {16'h0, inH};
  wire [31:0] wi  = w32 * {16'h0, i};
  wire [31:0] hj  = h32 * {16'h0, j};
  wire [31:0] colNum = bil ? wi : (wi << 1) + w32;
  wire [31:0] rowNum = bil ? hj : (hj << 1) + h32;
  wire [15:0] colDen = bil ? outW : {outW[14:0], 1'b0};
  wire [15:0] rowDen = bil ? outH : {outH[14:0], 1'b0};
  wire [15:0] maxW   = (inW > outW) ? inW : outW;
  wire [15:0] maxH   = (inH > outH) ? inH : outH;
  wire [31:0] errNumH = {16'h0, divRem} << `FRAC_H;
  wire [31:0] errNumV = {16'h0, divRem} << `FRAC_V;

  wire [`CNT_W-1:0] col1 = (srcCol + 16'h0001 < inW) ?
                           srcCol + 16'h0001 : srcCol;
  wire [`CNT_W-1:0] needRow = (bil && srcRow + 16'h0001 < inH) ?
                              srcRow + 16'h0001 : srcRow;
  wire wrSel  = bil & y[0];
  wire topSel = bil & srcRow[0];
  wire botSel = bil & needRow[0];
  // no beat accepted once the rows needed are stored
  assign dinReady = (state == S_IDLE && go) || state == S_CTRL ||
                    state == S_DROP || state == S_STREAM ||
                    (state == S_LOAD && y <= needRow);
  wire [`RAM_AW-1:0] rdAddr = (state == S_READ) ?
                              srcCol[`RAM_AW-1:0] : col1[`RAM_AW-1:0];

  // ==========================================================
  // bilinear blend
  // ==========================================================
  wire [4:0]         wH0 = `ONE_H - {1'b0, errI};
  wire [4:0]         wH1 = {1'b0, errI};
  wire [3:0]         wV0 = `ONE_V - {1'b0, errJ};
  wire [3:0]         wV1 = {1'b0, errJ};
  wire [`MUL_W-1:0]  wTL = wH0 * wV0;
  wire [`MUL_W-1:0]  wTR = wH1 * wV0;
  wire [`MUL_W-1:0]  wBL = wH0 * wV1;
  wire [`MUL_W-1:0]  wBR = wH1 * wV1;
  wire [16:0]        mA  = pA * wTL;
  wire [16:0]        mB  = pB * wTR;
  wire [16:0]        mC  = pC * wBL;
  wire [16:0]        mD  = pD * wBR;
  wire [18:0]        acc = {2'h0, mA} + {2'h0, mB} +
                           {2'h0, mC} + {2'h0, mD};
  wire [`DATA_W-1:0] blend = acc[`ACC_LSB+`DATA_W-1:`ACC_LSB];

  wire lastPix = (i + 16'h0001 == outW) && (j + 16'h0001 == outH);
  wire hit     = (y == srcRow) && (x == srcCol) && (i < outW);
  wire rowEnd  = (x + 16'h0001 == inW);

  // ==========================================================
  // line stores and divider
  // ==========================================================
  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1)
    begin : g_line
      scaler_line_ram u_ram
      (
        .clk    (sys_clk),
        .rstN   (rstN),
        .wrEn   (take && state == S_LOAD && wrSel == k),
        .wrAddr (x[`RAM_AW-1:0]),
        .wrData (dinData),
        .rdAddr (rdAddr),
        .rdData (rdBus[k])
      );
    end
  endgenerate

  scaler_divider u_div
  (
    .clk   (sys_clk),
    .rstN  (rstN),
    .start (divStart),
    .num   (divNum),
    .den   (divDen),
    .done  (divDone),
    .quot  (divQuot),
    .rem   (divRem)
  );

  // ==========================================================
  // register bus slave
  // ==========================================================
  wire avReq = avRead | avWrite;
  assign avWaitRequest = avReq & ~avAck;

  always @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      avAck      <= 1'b0;
      avReadData <= 32'h0;
      go         <= 1'b0;
      bilCfg     <= 1'b0;
      regOutW    <= `MAX_W;
      regOutH    <= `MAX_H;
    end
    else
    begin
      avAck <= avReq & ~avAck;
      if (avRead && !avAck)
      begin
        case (avAddress)
          `REG_CTRL:   avReadData <= {30'h0, bilCfg, go};
          `REG_STATUS: avReadData <= {31'h0, state != S_IDLE};
          `REG_OUTW:   avReadData <= {16'h0, regOutW};
          `REG_OUTH:   avReadData <= {16'h0, regOutH};
          `REG_INW:    avReadData <= {16'h0, inW};
          `REG_INH:    avReadData <= {16'h0, inH};
          default:     avReadData <= 32'h0;
        endcase
      end
      if (avWrite && avAck)
      begin
        case (avAddress)
          `REG_CTRL:
          begin
            go     <= avWriteData[`CTRL_GO];
            bilCfg <= avWriteData[`CTRL_BIL];
          end
          `REG_OUTW: regOutW <= avWriteData[15:0];
          `REG_OUTH: regOutH <= avWriteData[15:0];
          default:   ;
        endcase
      end
    end
  end

  // ==========================================================
  // frame engine
  // ==========================================================
  task finish_row;
    begin
      i <= 16'h0;
      j <= j + 16'h0001;
      if (j + 16'h0001 == outH)
        state <= inDone ? S_IDLE : S_DROP;
      else
        state <= S_ROWCALC;
    end
  endtask

  always @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state <= S_IDLE;
      inW <= `MAX_W;
      inH <= `MAX_H;
      newW <= 16'h0;
      newH <= 16'h0;
      ctlBeat <= 4'h0;
      outW <= `MAX_W;
      outH <= `MAX_H;
      bil <= 1'b0;
      direct <= 1'b0;
      inDone <= 1'b0;
      i <= 16'h0;
      j <= 16'h0;
      x <= 16'h0;
      y <= 16'h0;
      srcCol <= 16'h0;
      srcRow <= 16'h0;
      errI <= {`FRAC_H{1'b0}};
      errJ <= {`FRAC_V{1'b0}};
      pA <= {`DATA_W{1'b0}};
      pB <= {`DATA_W{1'b0}};
      pC <= {`DATA_W{1'b0}};
      pD <= {`DATA_W{1'b0}};
      divStart <= 1'b0;
      divNum <= 32'h0;
      divDen <= 16'h0;
      doutData <= {`DATA_W{1'b0}};
      doutValid <= 1'b0;
      doutStartOfPacket <= 1'b0;
      doutEndOfPacket <= 1'b0;
    end
    else
    begin
      divStart <= 1'b0;
      if (take && dinEndOfPacket && (state == S_LOAD ||
          state == S_STREAM))
        inDone <= 1'b1;
      case (state)
        S_IDLE:
          if (take && dinStartOfPacket)
          begin
            ctlBeat <= 4'h0;
            if (dinData[3:0] == `PKT_CTRL)
              state <= S_CTRL;
            else if (dinData[3:0] == `PKT_VIDEO)
            begin
              outW   <= regOutW;
              outH   <= regOutH;
              bil    <= bilCfg;
              direct <= !bilCfg && regOutW <= inW && regOutH <= inH;
              inDone <= 1'b0;
              i <= 16'h0;
              j <= 16'h0;
              x <= 16'h0;
              y <= 16'h0;
              doutData <= {{(`DATA_W-4){1'b0}}, `PKT_VIDEO};
              doutValid <= 1'b1;
              doutStartOfPacket <= 1'b1;
              state <= dinEndOfPacket ? S_IDLE : S_OUTHDR;
            end
            else if (!dinEndOfPacket)
              state <= S_DROP;
          end
        S_CTRL:
          if (take)
          begin
            if (ctlBeat < 4'h4)
              newW <= {newW[11:0], dinData[3:0]};
            else if (ctlBeat < `CTL_BEATS)
              newH <= {newH[11:0], dinData[3:0]};
            if (ctlBeat != 4'hf)
              ctlBeat <= ctlBeat + 4'h1;
            if (dinEndOfPacket)
            begin
              state <= S_IDLE;
              if (ctlBeat >= `CTL_BEATS - 4'h1)
              begin
                inW <= newW;
                inH <= {newH[11:0], dinData[3:0]};
              end
            end
          end
        S_DROP:
          if (take && dinEndOfPacket)
            state <= S_IDLE;
        S_OUTHDR:
          if (outTake)
          begin
            doutValid <= 1'b0;
            doutStartOfPacket <= 1'b0;
            state <= S_ROWCALC;
          end
        S_ROWCALC:
        begin
          divNum <= rowNum;
          divDen <= rowDen;
          divStart <= 1'b1;
          state <= S_ROWDIV;
        end
        S_ROWDIV:
          if (divDone)
          begin
            srcRow <= divQuot[15:0];
            if (bil)
            begin
              divNum <= errNumV;
              divDen <= maxH;
              divStart <= 1'b1;
              state <= S_ROWERR;
            end
            else
              state <= direct ? S_COLCALC : S_LOAD;
          end
        S_ROWERR:
          if (divDone)
          begin
            errJ <= divQuot[`FRAC_V-1:0];
            state <= S_LOAD;
          end
        S_LOAD:
          if (y > needRow)
            state <= S_COLCALC;
          else if (take)
          begin
            x <= rowEnd ? 16'h0 : x + 16'h0001;
            if (rowEnd)
              y <= y + 16'h0001;
          end
        S_COLCALC:
        begin
          divNum <= colNum;
          divDen <= colDen;
          divStart <= 1'b1;
          state <= S_COLDIV;
        end
        S_COLDIV:
          if (divDone)
          begin
            srcCol <= divQuot[15:0];
            if (bil)
            begin
              divNum <= errNumH;
              divDen <= maxW;
              divStart <= 1'b1;
              state <= S_COLERR;
            end
            else
              state <= direct ? S_STREAM : S_READ;
          end
        S_COLERR:
          if (divDone)
          begin
            errI <= divQuot[`FRAC_H-1:0];
            state <= S_READ;
          end
        S_READ:
          state <= S_READ2;
        S_READ2:
        begin
          pA <= rdBus[topSel];
          pC <= rdBus[botSel];
          state <= S_READ3;
        end
        S_READ3:
        begin
          pB <= rdBus[topSel];
          pD <= rdBus[botSel];
          state <= S_CALC;
        end
        S_CALC:
        begin
          doutData <= bil ? blend : pA;
          doutValid <= 1'b1;
          doutEndOfPacket <= lastPix;
          state <= S_EMIT;
        end
        S_STREAM:
          if (take)
          begin
            x <= rowEnd ? 16'h0 : x + 16'h0001;
            if (rowEnd)
              y <= y + 16'h0001;
            if (hit)
            begin
              doutData <= dinData;
              doutValid <= 1'b1;
              doutEndOfPacket <= lastPix;
              state <= S_EMIT;
            end
            else if (rowEnd && y == srcRow)
              finish_row;
          end
        S_EMIT:
          if (outTake)
          begin
            doutValid <= 1'b0;
            doutEndOfPacket <= 1'b0;
            i <= i + 16'h0001;
            if (direct && x == 16'h0)
              finish_row;
            else if (i + 16'h0001 < outW)
              state <= S_COLCALC;
            else if (direct)
              state <= S_STREAM;
            else
              finish_row;
          end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- tb/video_scaler_monitor.sv ----
// Purpose: port checker of the video scaler
// Assumes: sees only the top module ports
// Notes:   bound below the module
`include "scaler_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module video_scaler_monitor
(
  // clock and reset
  input wire               sys_clk,
  input wire               rst_n,
  // register bus
  input wire [2:0]         avAddress,
  input wire               avRead,
  input wire               avWrite,
  input wire [31:0]        avWriteData,
  input wire [31:0]        avReadData,
  input wire               avWaitRequest,
  // video in
  input wire [`DATA_W-1:0] dinData,
  input wire               dinValid,
  input wire               dinStartOfPacket,
  input wire               dinEndOfPacket,
  input wire               dinReady,
  // video out
  input wire [`DATA_W-1:0] doutData,
  input wire               doutValid,
  input wire               doutStartOfPacket,
  input wire               doutEndOfPacket,
  input wire               doutReady
);
  // ====
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire req = avRead | avWrite;
  property p_firstWait;
    $rose(req) |-> avWaitRequest;
  endproperty
  a_firstWait: assert property (p_firstWait) else $error("no wait");
  property p_oneWait;
    req && avWaitRequest |=> !avWaitRequest;
  endproperty
  a_oneWait: assert property (p_oneWait) else $error("long wait");
  property p_idleWait;
    !req |-> !avWaitRequest;
  endproperty
  a_idleWait: assert property (p_idleWait) else $error("idle wait");
  property p_unmapped;
    avRead && !avWaitRequest && avAddress > 3'h5 |-> avReadData == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
  property p_outHold;
    doutValid && !doutReady |=> doutValid && $stable(doutData)
      && $stable(doutStartOfPacket) && $stable(doutEndOfPacket);
  endproperty
  a_outHold: assert property (p_outHold) else $error("beat lost");
  property p_header;
    dinValid && dinReady && dinStartOfPacket
      && dinData[3:0] == `PKT_VIDEO |=> doutValid && doutStartOfPacket
      && doutData == 8'h00;
  endproperty
  a_header: assert property (p_header) else $error("no header");
  property p_videoOnly;
    doutValid && doutStartOfPacket |-> doutData[3:0] == `PKT_VIDEO;
  endproperty
  a_videoOnly: assert property (p_videoOnly) else $error("bad type");
  property p_busyIn;
    doutValid |-> !dinReady;
  endproperty
  a_busyIn: assert property (p_busyIn) else $error("ready early");
  property p_resetOut;
    $rose(rst_n) |-> !doutValid && !dinReady;
  endproperty
  a_resetOut: assert property (p_resetOut) else $error("reset out");
  c_header: cover property (doutValid && doutStartOfPacket && doutReady);
  c_stall: cover property (doutValid && !doutReady);
  c_unmap: cover property (avRead && !avWaitRequest && avAddress > 3'h5);
endmodule
bind video_scaler_nn_bilinear video_scaler_monitor mon
(
  .sys_clk(sys_clk), .rst_n(rst_n), .avAddress(avAddress),
  .avRead(avRead), .avWrite(avWrite), .avWriteData(avWriteData),
  .avReadData(avReadData), .avWaitRequest(avWaitRequest),
  .dinData(dinData), .dinValid(dinValid),
  .dinStartOfPacket(dinStartOfPacket), .dinEndOfPacket(dinEndOfPacket),
  .dinReady(dinReady), .doutData(doutData), .doutValid(doutValid),
  .doutStartOfPacket(doutStartOfPacket),
  .doutEndOfPacket(doutEndOfPacket), .doutReady(doutReady)
);
`default_nettype wire

// ---- tb/video_sink_model.sv ----
// Purpose: downstream stream sink with optional stalls
// Assumes: one beat per valid and ready edge
// Notes:   beats kept as {sop, eop, data}
`include "scaler_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module video_sink_model
(
  // clock and reset
  input wire               clk,
  input wire               rstN,
  // bench control
  input wire               clr,
  input wire               stall,
  // stream from the scaler
  input wire [`DATA_W-1:0] data,
  input wire               valid,
  input wire               sop,
  input wire               eop,
  output logic             ready
);
  logic [9:0] beats [0:63];
  int         n;
  logic [1:0] tick;
  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ready <= 1'b0;
      tick  <= 2'h0;
      n     <= 0;
    end
    else
    begin
      tick  <= tick + 2'h1;
      ready <= !(stall && tick[1]);
      if (clr)
        n <= 0;
      else if (valid && ready && n < 64)
      begin
        beats[n] <= {sop, eop, data};
        n        <= n + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/video_scaler_nn_bilinear_tb.sv ----
// Purpose: self-checking bench of the video scaler
// Assumes: 4x2 input frames, one plane
// Notes:   expected pixels from the scaling formulas
`include "scaler_defines.vh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  failures++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module video_scaler_nn_bilinear_tb;
  localparam int IW = 4;
  localparam int IH = 2;
  localparam logic [31:0] DEFS [0:7] =
    '{0, 0, 32'h280, 32'h1e0, 32'h280, 32'h1e0, 0, 0};
  logic sys_clk, rst_n, avRead, avWrite, avWaitRequest, clr, stall;
  logic [2:0] avAddress;
  logic [31:0] avWriteData, avReadData, q;
  logic [7:0] dinData, doutData;
  logic dinValid, dinStartOfPacket, dinEndOfPacket, dinReady;
  logic doutValid, doutStartOfPacket, doutEndOfPacket, doutReady;
  int failures = 0, check_count = 0, cycles = 0;
  video_scaler_nn_bilinear DUT
  (
    .sys_clk(sys_clk), .rst_n(rst_n), .avAddress(avAddress),
    .avRead(avRead), .avWrite(avWrite), .avWriteData(avWriteData),
    .avReadData(avReadData), .avWaitRequest(avWaitRequest),
    .dinData(dinData), .dinValid(dinValid),
    .dinStartOfPacket(dinStartOfPacket), .dinEndOfPacket(dinEndOfPacket),
    .dinReady(dinReady), .doutData(doutData), .doutValid(doutValid),
    .doutStartOfPacket(doutStartOfPacket),
    .doutEndOfPacket(doutEndOfPacket), .doutReady(doutReady)
  );
  video_sink_model sink
  (
    .clk(sys_clk), .rstN(rst_n), .clr(clr), .stall(stall),
    .data(doutData), .valid(doutValid), .sop(doutStartOfPacket),
    .eop(doutEndOfPacket), .ready(doutReady)
  );
  // ====
  // clock, timeout, verdict
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      failures++;
      tally_and_finish;
    end
  end
  task automatic tally_and_finish;
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ====
  // bus and stream tasks
  task automatic bus(input logic wr, input logic [2:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    avAddress   <= a;
    avWriteData <= d;
    avWrite     <= wr;
    avRead      <= !wr;
    do @(posedge sys_clk); while (avWaitRequest !== 1'b0);
    q = avReadData;
    avWrite <= 1'b0;
    avRead  <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  task automatic beat(input logic [7:0] d, input logic s, input logic e);
    dinData          <= d;
    dinStartOfPacket <= s;
    dinEndOfPacket   <= e;
    dinValid         <= 1'b1;
    do @(negedge sys_clk); while (dinReady !== 1'b1);
    @(posedge sys_clk);
  endtask
  function automatic logic [7:0] px(input int x, input int y);
    return 8'(20 + 37 * x + 61 * y);
  endfunction
  // expected output pixel at column i, row j
  function automatic logic [7:0] want(input int i, j, ow, oh,
                                      input logic bil);
    int x0, y0, x1, y1, ei, ej, s;
    if (!bil)
      return px((2 * IW * i + IW) / (2 * ow), (2 * IH * j + IH) / (2 * oh));
    x0 = i * IW / ow;
    y0 = j * IH / oh;
    x1 = (x0 < IW - 1) ? x0 + 1 : x0;
    y1 = (y0 < IH - 1) ? y0 + 1 : y0;
    ei = ((i * IW) % ow) * 16 / (IW > ow ? IW : ow);
    ej = ((j * IH) % oh) * 8 / (IH > oh ? IH : oh);
    s = px(x0, y0) * (16 - ei) * (8 - ej) + px(x1, y0) * ei * (8 - ej)
      + px(x0, y1) * (16 - ei) * ej + px(x1, y1) * ei * ej;
    return 8'(s >> 7);
  endfunction
  task automatic frame(input int ow, oh, input logic bil, slow);
    logic [9:0] e10;
    bus(1'b1, `REG_OUTW, 32'(ow));
    bus(1'b1, `REG_OUTH, 32'(oh));
    bus(1'b1, `REG_CTRL, {30'h0, bil, 1'b1});
    stall <= slow;
    clr   <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    beat(8'h00, 1'b1, 1'b0);
    for (int k = 0; k < IW * IH; k++)
      beat(px(k % IW, k / IW), 1'b0, k == IW * IH - 1);
    dinValid <= 1'b0;
    for (int c = 0; c < 20000 && sink.n < 1 + ow * oh; c++)
      @(posedge sys_clk);
    repeat (100) @(posedge sys_clk);
    `CHK(sink.n, 1 + ow * oh)
    `CHK(sink.beats[0], 10'h200)
    for (int k = 0; k < ow * oh; k++)
    begin
      e10 = {1'b0, k == ow * oh - 1, want(k % ow, k / ow, ow, oh, bil)};
      `CHK(sink.beats[k + 1], e10)
    end
  endtask
  // ====
  // test sequence
  initial
  begin
    rst_n            = 1'b0;
    {avRead, avWrite, clr, stall, dinValid} = 5'h0;
    {dinStartOfPacket, dinEndOfPacket} = 2'h0;
    avAddress        = 3'h0;
    avWriteData      = 32'h0;
    dinData          = 8'h00;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int k = 0; k < 8; k++) rd(3'(k), DEFS[k]);
    bus(1'b1, `REG_INW, 32'h5);
    rd(`REG_INW, 32'h280);
    bus(1'b1, `REG_CTRL, 32'h1);
    beat({4'h0, `PKT_CTRL}, 1'b1, 1'b0);
    for (int k = 7; k >= 0; k--)
      beat({4'h0, 4'(k < 4 ? IH >> 4 * k : IW >> 4 * (k - 4))}, 1'b0,
           k == 0);
    dinValid <= 1'b0;
    rd(`REG_INW, 32'(IW));
    rd(`REG_INH, 32'(IH));
    frame(2, 1, 1'b0, 1'b0);
    frame(5, 3, 1'b0, 1'b1);
    frame(6, 3, 1'b1, 1'b1);
    frame(3, 1, 1'b1, 1'b0);
    rd(`REG_CTRL, 32'h3);
    tally_and_finish;
  end
endmodule
`default_nettype wire
